// *** asp_defines.vh ***
// constants of the audio sample playback engine
// assumes a 100 MHz system clock and byte-wide sample memory
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH

`define ASP_CLK_HZ        27'h5f5e100
`define ASP_ACC_W         27
`define ASP_FMT_PCM8      2'h0
`define ASP_FMT_MULAW8    2'h1
`define ASP_FMT_IMA4      2'h2
`define ASP_FMT_SILENT    2'h3
`define ASP_MULAW_BIAS    16'h0084
`define ASP_IMA_IDX_MAX   7'h58
`define ASP_IDX_W         7
`define ASP_PWM_MID       8'h80
`define ASP_SAMPLE_W      16

`endif

// *** asp_fifo.v ***
// byte FIFO with a registered output stage
// assumes one clock and a synchronous active-low reset
module asp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  reg             ov_q;
  reg [WIDTH-1:0] od_q;

  wire mem_empty = (wr_q == rd_q);
  wire mem_full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire push      = in_valid && !mem_full;
  wire pop_out   = ov_q && out_ready;
  wire load      = !mem_empty && (!ov_q || pop_out);

  assign in_ready  = !mem_full;
  assign out_valid = ov_q;
  assign out_data  = od_q;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (push && !flush)
    begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b || flush)
    begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
      ov_q <= 1'b0;
      od_q <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (load)
      begin
        rd_q <= rd_q + 1'b1;
        od_q <= mem[rd_q[AW-1:0]];
        ov_q <= 1'b1;
      end
      else if (pop_out)
      begin
        ov_q <= 1'b0;
      end
    end
  end

endmodule

// *** asp_player.v ***
// audio sample playback engine: fetch, buffer, decode, scale, pwm
// assumes a byte memory answering each read with RAM_RD_VALID later
//
// How it works
// - fetching starts at the start address
// - length counts bytes to consume
// - output rate is the hertz setting
// - format picks linear, mu-law, ADPCM or silent
// - loop 0 plays once, 1 repeats; in the silent format 1 stops fetching and holds busy
// - a play write with nonzero length starts playback
// - busy reads 1 while playing
// - output scaled by 0-255 volume
// - pcm8, mu-law8 and 4-bit IMA supported
// - low nibble plays before high nibble
// - fetch pointer always readable
// - mono output on one pwm pin
`include "asp_defines.vh"
module asp_player #(
  parameter AW     = 20,
  parameter LW     = 20,
  parameter RW     = 16,
  parameter FDEPTH = 16,
  parameter FAW    = 4
) (
  input  wire          SYS_CLK,
  input  wire          RST_B,
  input  wire [AW-1:0] PB_START_ADDR,
  input  wire [LW-1:0] PB_LENGTH,
  input  wire [RW-1:0] PB_SAMPLE_RATE_HZ,
  input  wire [1:0]    PB_FORMAT,
  input  wire          PB_LOOP,
  input  wire          PB_PLAY_WRITE,
  input  wire [7:0]    PB_VOLUME,
  output wire          PB_PLAY_BUSY,
  output wire [AW-1:0] PB_FETCH_POINTER,
  output wire          RAM_RD_REQ,
  output wire [AW-1:0] RAM_RD_ADDR,
  input  wire          RAM_RD_VALID,
  input  wire [7:0]    RAM_RD_DATA,
  output wire          AUDIO_PWM
);

  localparam [1423:0] STEP_TBL = {
    16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c,
    16'h000d, 16'h000e, 16'h0010, 16'h0011, 16'h0013, 16'h0015,
    16'h0017, 16'h0019, 16'h001c, 16'h001f, 16'h0022, 16'h0025,
    16'h0029, 16'h002d, 16'h0032, 16'h0037, 16'h003c, 16'h0042,
    16'h0049, 16'h0050, 16'h0058, 16'h0061, 16'h006b, 16'h0076,
    16'h0082, 16'h008f, 16'h009d, 16'h00ad, 16'h00be, 16'h00d1,
    16'h00e6, 16'h00fd, 16'h0117, 16'h0133, 16'h0151, 16'h0173,
    16'h0198, 16'h01c1, 16'h01ee, 16'h0220, 16'h0256, 16'h0292,
    16'h02d4, 16'h031c, 16'h036c, 16'h03c3, 16'h0424, 16'h048e,
    16'h0502, 16'h0583, 16'h0610, 16'h06ab, 16'h0756, 16'h0812,
    16'h08e0, 16'h09c3, 16'h0abd, 16'h0bd0, 16'h0cff, 16'h0e4c,
    16'h0fba, 16'h114c, 16'h1307, 16'h14ee, 16'h1706, 16'h1954,
    16'h1bdc, 16'h1ea5, 16'h21b6, 16'h2515, 16'h28ca, 16'h2cdf,
    16'h315b, 16'h364b, 16'h3bb9, 16'h41b2, 16'h4844, 16'h4f7e,
    16'h5771, 16'h602f, 16'h69ce, 16'h7462, 16'h7fff};

  // step size for an ADPCM index, entry 0 stored in the top bits
  function [15:0] ima_step;
    input [`ASP_IDX_W-1:0] idx;
    begin
      ima_step = STEP_TBL[16*(`ASP_IMA_IDX_MAX - idx) +: 16];
    end
  endfunction

  // logarithmic expansion of one mu-law byte
  function [15:0] mulaw_dec;
    input [7:0] b;
    reg   [7:0]  u;
    reg   [15:0] mag;
    begin
      u = ~b;
      mag = ({8'h00, 1'b0, u[3:0], 3'h0} + `ASP_MULAW_BIAS) << u[6:4];
      mag = mag - `ASP_MULAW_BIAS;
      mulaw_dec = u[7] ? (16'h0000 - mag) : mag;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg                    busy_q;
  reg [AW-1:0]           start_q;
  reg [AW-1:0]           addr_q;
  reg [LW-1:0]           len_q;
  reg [LW-1:0]           fcnt_q;
  reg [LW-1:0]           ccnt_q;
  reg [1:0]              fmt_q;
  reg                    pend_q;
  reg                    drop_q;
  reg                    nib_q;
  reg [`ASP_ACC_W-1:0]   acc_q;
  reg [15:0]             sample_q;
  reg [15:0]             pred_q;
  reg [`ASP_IDX_W-1:0]   idx_q;
  reg [15:0]             scaled_q;
  reg [7:0]              pwm_cnt_q;
  reg                    pwm_q;

  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;

  wire [`ASP_ACC_W-1:0] acc_sum =
    acc_q + {{(`ASP_ACC_W-RW){1'b0}}, PB_SAMPLE_RATE_HZ};
  wire tick = (acc_sum >= `ASP_CLK_HZ);

  wire issue = busy_q && !pend_q && fifo_in_ready && (fcnt_q != len_q);
  wire is_ima = (fmt_q == `ASP_FMT_IMA4);
  wire take = tick && busy_q && fifo_out_valid;
  wire byte_done = take && (!is_ima || nib_q);
  wire last_byte = (ccnt_q + 1'b1 == len_q);

  assign PB_PLAY_BUSY     = busy_q;
  assign PB_FETCH_POINTER = addr_q;
  assign RAM_RD_REQ       = issue;
  assign RAM_RD_ADDR      = addr_q;
  assign AUDIO_PWM        = pwm_q;

  asp_fifo #(
    .WIDTH (8),
    .DEPTH (FDEPTH),
    .AW    (FAW)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .flush     (PB_PLAY_WRITE),
    .in_valid  (RAM_RD_VALID && !drop_q),
    .in_ready  (fifo_in_ready),
    .in_data   (RAM_RD_DATA),
    .out_valid (fifo_out_valid),
    .out_ready (byte_done),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoders
  reg  [3:0]            nib;
  reg  [15:0]           step;
  reg  [16:0]           diff;
  reg  [17:0]           psum;
  reg  [15:0]           ima_pred;
  reg  [7:0]            idx_sum;
  reg  [`ASP_IDX_W-1:0] ima_idx;
  reg  [15:0]           decoded;

  always @*
  begin
    nib = nib_q ? fifo_out_data[7:4] : fifo_out_data[3:0];
    step = ima_step(idx_q);
    diff = {4'h0, step[15:3]};
    if (nib[2])
      diff = diff + {1'b0, step};
    if (nib[1])
      diff = diff + {2'b00, step[15:1]};
    if (nib[0])
      diff = diff + {3'b000, step[15:2]};
    if (nib[3])
      psum = {{2{pred_q[15]}}, pred_q} - {1'b0, diff};
    else
      psum = {{2{pred_q[15]}}, pred_q} + {1'b0, diff};
    if (psum[17] && psum[16:15] != 2'h3)
      ima_pred = 16'h8000;
    else if (!psum[17] && psum[16:15] != 2'h0)
      ima_pred = 16'h7fff;
    else
      ima_pred = psum[15:0];
    if (nib[2])
      idx_sum = {1'b0, idx_q} + {4'h0, ({1'b0, nib[1:0]} + 3'h1), 1'b0};
    else
      idx_sum = {1'b0, idx_q} - 8'h01;
    if (!nib[2] && idx_q == {`ASP_IDX_W{1'b0}})
      ima_idx = {`ASP_IDX_W{1'b0}};
    else if (idx_sum > {1'b0, `ASP_IMA_IDX_MAX})
      ima_idx = `ASP_IMA_IDX_MAX;
    else
      ima_idx = idx_sum[`ASP_IDX_W-1:0];
    case (fmt_q)
      `ASP_FMT_PCM8:   decoded = {fifo_out_data, 8'h00};
      `ASP_FMT_MULAW8: decoded = mulaw_dec(fifo_out_data);
      `ASP_FMT_IMA4:   decoded = ima_pred;
      default:         decoded = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, fetch and consume
  always @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      busy_q   <= 1'b0;
      start_q  <= {AW{1'b0}};
      addr_q   <= {AW{1'b0}};
      len_q    <= {LW{1'b0}};
      fcnt_q   <= {LW{1'b0}};
      ccnt_q   <= {LW{1'b0}};
      fmt_q    <= `ASP_FMT_PCM8;
      pend_q   <= 1'b0;
      drop_q   <= 1'b0;
      nib_q    <= 1'b0;
      acc_q    <= {`ASP_ACC_W{1'b0}};
      sample_q <= 16'h0000;
      pred_q   <= 16'h0000;
      idx_q    <= {`ASP_IDX_W{1'b0}};
    end
    else if (PB_PLAY_WRITE)
    begin
      busy_q   <= (PB_LENGTH != {LW{1'b0}});
      start_q  <= PB_START_ADDR;
      addr_q   <= PB_START_ADDR;
      len_q    <= PB_LENGTH;
      fmt_q    <= PB_FORMAT;
      fcnt_q   <= {LW{1'b0}};
      ccnt_q   <= {LW{1'b0}};
      pend_q   <= 1'b0;
      drop_q   <= pend_q && !RAM_RD_VALID;
      nib_q    <= 1'b0;
      acc_q    <= {`ASP_ACC_W{1'b0}};
      sample_q <= 16'h0000;
      pred_q   <= 16'h0000;
      idx_q    <= {`ASP_IDX_W{1'b0}};
    end
    else
    begin
      acc_q <= tick ? (acc_sum - `ASP_CLK_HZ) : acc_sum;
      if (RAM_RD_VALID)
      begin
        pend_q <= 1'b0;
        drop_q <= 1'b0;
      end
      if (issue)
      begin
        pend_q <= 1'b1;
        if (fmt_q != `ASP_FMT_SILENT && PB_LOOP && fcnt_q + 1'b1 == len_q)
        begin
          fcnt_q <= {LW{1'b0}};
          addr_q <= start_q;
        end
        else
        begin
          fcnt_q <= fcnt_q + 1'b1;
          addr_q <= addr_q + 1'b1;
        end
      end
      if (take)
      begin
        sample_q <= decoded;
        if (is_ima)
        begin
          pred_q <= ima_pred;
          idx_q  <= ima_idx;
          nib_q  <= !nib_q;
        end
      end
      if (byte_done)
      begin
        ccnt_q <= ccnt_q + 1'b1;
        if (last_byte)
        begin
          ccnt_q <= {LW{1'b0}};
          pred_q <= 16'h0000;
          idx_q  <= {`ASP_IDX_W{1'b0}};
          if (!PB_LOOP)
          begin
            busy_q   <= 1'b0;
            sample_q <= 16'h0000;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // volume scaling
  wire signed [24:0] prod = $signed(sample_q) * $signed({1'b0, PB_VOLUME});
  wire [7:0] duty = scaled_q[15:8] ^ `ASP_PWM_MID;

  always @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      scaled_q  <= 16'h0000;
      pwm_cnt_q <= 8'h00;
      pwm_q     <= 1'b0;
    end
    else
    begin
      scaled_q  <= prod[23:8];
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      pwm_q     <= (pwm_cnt_q < duty);
    end
  end

endmodule

// *** asp_monitor.sv ***
// port checker of the playback engine
// assumes a bind onto every asp_player instance
module asp_monitor #(
  parameter AW = 20,
  parameter LW = 20
) (
  input wire          SYS_CLK,
  input wire          RST_B,
  input wire [AW-1:0] PB_START_ADDR,
  input wire [LW-1:0] PB_LENGTH,
  input wire          PB_LOOP,
  input wire          PB_PLAY_WRITE,
  input wire          PB_PLAY_BUSY,
  input wire [AW-1:0] PB_FETCH_POINTER,
  input wire          RAM_RD_REQ,
  input wire [AW-1:0] RAM_RD_ADDR,
  input wire          RAM_RD_VALID
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  reg [AW-1:0] st_q;
  reg [AW-1:0] last_q;
  reg          pend_q;
  always @(posedge SYS_CLK)
  begin
    if (PB_PLAY_WRITE)
      st_q <= PB_START_ADDR;
    if (RAM_RD_REQ)
      last_q <= RAM_RD_ADDR;
    if (!RST_B || RAM_RD_VALID || PB_PLAY_WRITE)
      pend_q <= 1'b0;
    else if (RAM_RD_REQ)
      pend_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_go;
    PB_PLAY_WRITE && PB_LENGTH != 0;
  endsequence
  sequence s_fetch0;
    RAM_RD_REQ && RAM_RD_ADDR == st_q;
  endsequence
  a_play_busy: assert property (s_go |=> PB_PLAY_BUSY)
    else $error("busy not raised after play");
  a_first_fetch: assert property (s_go |=> ##[0:7] s_fetch0)
    else $error("first fetch not at start address");
  a_zero_len: assert property (PB_PLAY_WRITE && PB_LENGTH == 0 &&
    !PB_PLAY_BUSY |=> !PB_PLAY_BUSY [*3])
    else $error("zero length started playback");
  a_ptr_addr: assert property (!RAM_RD_REQ && !PB_PLAY_WRITE |=>
    $stable(PB_FETCH_POINTER))
    else $error("fetch pointer moved without a fetch");
  a_seq_addr: assert property (RAM_RD_REQ |->
    RAM_RD_ADDR == last_q + 1'b1 || RAM_RD_ADDR == st_q)
    else $error("fetch address not sequential");
  a_one_read: assert property (RAM_RD_REQ |-> !pend_q)
    else $error("second read while one outstanding");
  a_req_busy: assert property (RAM_RD_REQ |-> PB_PLAY_BUSY)
    else $error("fetch while idle");
  a_loop_hold: assert property (PB_PLAY_BUSY && PB_LOOP &&
    !PB_PLAY_WRITE |=> PB_PLAY_BUSY)
    else $error("looped playback ended");
  a_busy_cause: assert property ($rose(PB_PLAY_BUSY) |->
    $past(PB_PLAY_WRITE) && $past(PB_LENGTH) != 0)
    else $error("busy rose without play");
endmodule
bind asp_player asp_monitor #(.AW(AW), .LW(LW)) u_asp_monitor (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .PB_START_ADDR(PB_START_ADDR),
  .PB_LENGTH(PB_LENGTH), .PB_LOOP(PB_LOOP), .PB_PLAY_WRITE(PB_PLAY_WRITE),
  .PB_PLAY_BUSY(PB_PLAY_BUSY), .PB_FETCH_POINTER(PB_FETCH_POINTER),
  .RAM_RD_REQ(RAM_RD_REQ), .RAM_RD_ADDR(RAM_RD_ADDR),
  .RAM_RD_VALID(RAM_RD_VALID));

// *** asp_filter.sv ***
// averaging model of the low-pass filter on the pwm pin
// assumes a pwm period of 256 clocks
module asp_filter (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       pwm,
  output reg  [8:0] duty_q
);
  reg [255:0] hist_q;
  always @(posedge clk)
  begin
    hist_q <= rst_b ? {hist_q[254:0], pwm} : 256'h0;
    duty_q <= rst_b ? duty_q + pwm - hist_q[255] : 9'h0;
  end
endmodule

// *** tb.sv ***
// self-checking bench of the playback engine
// assumes asp_player, asp_filter and the bound monitor
`include "asp_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        SYS_CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic [19:0] st = 20'h0;
  logic [19:0] len = 20'h0;
  logic [15:0] rate = 16'hc350;
  logic [1:0]  fmt = 2'h0;
  logic        lp = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  vol = 8'h0;
  logic        vld = 1'b0;
  logic [7:0]  rdat = 8'h0;
  logic [7:0]  fill = 8'h0;
  logic        busy;
  logic        req;
  logic        pwm;
  logic [19:0] ptr;
  logic [19:0] addr;
  logic [8:0]  duty;
  logic [31:0] seed = 32'h00017dfb;
  int          n_fail = 0;
  int          num_checks = 0;
  int          nrd = 0;
  int          cyc = 0;
  int          l;
  always #5 SYS_CLK = ~SYS_CLK;
  asp_player u_asp_player (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .PB_START_ADDR(st), .PB_LENGTH(len), .PB_SAMPLE_RATE_HZ(rate),
    .PB_FORMAT(fmt), .PB_LOOP(lp), .PB_PLAY_WRITE(go), .PB_VOLUME(vol),
    .PB_PLAY_BUSY(busy), .PB_FETCH_POINTER(ptr), .RAM_RD_REQ(req),
    .RAM_RD_ADDR(addr), .RAM_RD_VALID(vld), .RAM_RD_DATA(rdat),
    .AUDIO_PWM(pwm));
  asp_filter u_asp_filter (.clk(SYS_CLK), .rst_b(RST_B), .pwm(pwm),
    .duty_q(duty));
  ////////////////////////////////////////////////////////////////////////////
  // memory model returning the fill byte on every read
  // memory answering one cycle later, data inverted when not valid
  always @(posedge SYS_CLK)
  begin
    cyc <= cyc + 1;
    vld <= req;
    rdat <= req ? fill : ~rdat;
    if (req)
      nrd <= nrd + 1;
  end
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function int tsamp(input int n);
    return n * 100000000 / rate;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task chk_in(input string nm, input int lo, input int hi,
              input logic [31:0] s);
    num_checks++;
    if ($isunknown(s) || s < lo || s > hi)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, s);
    end
  endtask
  task start(input logic [19:0] n);
    @(posedge SYS_CLK);
    len <= n;
    go <= 1'b1;
    nrd <= 0;
    @(posedge SYS_CLK);
    go <= 1'b0;
  endtask
  task idle(input int lim);
    int i;
    for (i = 0; i < lim && busy !== 1'b0; i++)
      @(negedge SYS_CLK);
  endtask
  task run(input logic [1:0] f, input logic [7:0] d, input logic [7:0] v,
           input int n, input int k, input int lo, input int hi);
    logic [31:0] r;
    int          t0;
    @(posedge SYS_CLK);
    r = xs();
    st <= r[19:0];
    rate <= 16'hc350 | r[30:16];
    fmt <= f;
    fill <= d;
    vol <= v;
    start(n[19:0]);
    t0 = cyc;
    repeat (tsamp(k) - tsamp(1) / 2) @(negedge SYS_CLK);
    chk_in("duty", lo, hi, duty);
    idle(tsamp(3));
    chk_in("time", tsamp(k - 1), tsamp(k + 1), cyc - t0);
    chk("ptr", st + len, ptr);
    chk("reads", n, nrd);
  endtask
  task summarize();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #1200000;
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    @(negedge SYS_CLK);
    chk("ptr0", 20'h0, ptr);
    start(20'h0);
    repeat (3) @(negedge SYS_CLK);
    chk("busy0", 1'b0, busy);
    l = 2 + xs() % 4;
    run(`ASP_FMT_PCM8, 8'h60, 8'hff, l, l, 160, 256);
    run(`ASP_FMT_PCM8, 8'h60, 8'h00, l, l, 126, 130);
    run(`ASP_FMT_MULAW8, 8'h80, 8'hff, l, l, 160, 256);
    run(`ASP_FMT_MULAW8, 8'h00, 8'hff, l, l, 0, 96);
    run(`ASP_FMT_SILENT, 8'h60, 8'hff, l, l, 126, 130);
    run(`ASP_FMT_IMA4, 8'h77, 8'hff, 6, 12, 144, 256);
    @(posedge SYS_CLK);
    lp <= 1'b1;
    start(20'h2);
    repeat (tsamp(3)) @(negedge SYS_CLK);
    chk("loopbusy", 1'b1, busy);
    chk_in("loopreads", 3, 60, nrd);
    chk_in("loopptr", st, st + 1, ptr);
    @(posedge SYS_CLK);
    st <= st + 20'h10;
    lp <= 1'b0;
    start(20'h2);
    idle(tsamp(6));
    chk("loopend", 1'b0, busy);
    summarize();
  end
endmodule
